// *** tws_defines.svh ***
// constants of the two-wire memory target: codes, geometry, timing
// assumes a 10 MHz system clock and a 13-bit word address
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH

`define TWS_DEV_TYPE 4'hA
`define TWS_AW 13
`define TWS_DEPTH 8192
`define TWS_ERASED 8'hFF
`define TWS_HI_MASK 8'h1F
`define TWS_PROT_TOP 2'h3
`define TWS_LAST_BIT 4'h7
`define TWS_ACK_BIT 4'h8
`define TWS_CLK_KHZ 10000
`define TWS_PROG_MS 10
`define TWS_PROG_CW 17

`endif

// *** tws_pkg.sv ***
// types shared by the two-wire memory target
// assumes the shared constants header sits in the same folder
`include "tws_defines.svh"

package tws_pkg;

	// one-hot protocol phases; standby is idle with no program cycle running
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DEV = 6'h02,
		ST_AHI = 6'h04,
		ST_ALO = 6'h08,
		ST_WR = 6'h10,
		ST_RD = 6'h20
	} tws_state_e;

	typedef logic [`TWS_PROG_CW-1:0] tws_prog_cnt_t;

endpackage : tws_pkg

// *** tws_prog_timer.sv ***
// self-timed program interval counter
// assumes start is a one-cycle pulse in the clk domain
`timescale 1ns/10ps
`include "tws_defines.svh"

module tws_prog_timer #(
	parameter tws_pkg::tws_prog_cnt_t PROG_CYCLES =
		`TWS_PROG_CW'(`TWS_PROG_MS * `TWS_CLK_KHZ)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	output logic busy
);

	tws_pkg::tws_prog_cnt_t cnt_q;

	// counts down from the full interval, busy while nonzero
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			cnt_q <= '0;
		else if (start)
			cnt_q <= PROG_CYCLES;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	assign busy = (cnt_q != '0);

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	a_busy_holds: assert property (start |=> busy [*8])
		else $error("program interval ended too early");

endmodule : tws_prog_timer

// *** tws_eeprom.sv ***
// target-side protocol logic of a two-wire byte memory
// assumes scl and sda come from pins; sda open drain, resolved outside;
// the bus controller is the only source of scl
`timescale 1ns/10ps
`include "tws_defines.svh"

// How it works
// - sda changes with scl high are conditions
// - sda falling, scl high is start
// - sda rising, scl high is stop
// - acknowledge each received byte on ninth clock
// - standby at power-up and after stop
// - device word begins with fixed 1010
// - next three bits must match straps
// - last device bit selects read or write
// - ack on match, else back to standby
// - protect pin blocks writes to top quarter
// - write: two address bytes then data
// - after write stop, timed cycle ignores inputs
// - page write takes up to 32 bytes
// - write address wraps inside the page
// - device word acked only when not busy
// - address counter is last address plus one
// - read address wraps at end of memory
// - current read returns byte at counter
// - random read via dummy write, restart
// - controller ack continues sequential read
// - don't-care top bits of address ignored
// - sample on scl rise, drive after fall
// - 32-byte pages, 13-bit word address
// - protect input low when unconnected
module tws_eeprom #(
	parameter tws_pkg::tws_prog_cnt_t PROG_CYCLES =
		`TWS_PROG_CW'(`TWS_PROG_MS * `TWS_CLK_KHZ)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic chip_select_strap_2,
	input wire logic chip_select_strap_1,
	input wire logic chip_select_strap_0,
	input wire logic write_protect,
	output logic standby
);

	// link domain, clocked by scl itself
	logic bit_q;
	logic tog_q;
	logic drv_q;

	// clk domain
	logic scl_s1, scl_s2, sda_s1, sda_s2, sda_p;
	logic tog_s1, tog_s2, tog_p;
	logic [2:0] strap_s1, strap_s2;
	logic wp_s1, wp_s2;
	tws_pkg::tws_state_e state_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic [7:0] out_q;
	logic [7:0] hi_q;
	logic [`TWS_AW-1:0] addr_q;
	logic [7:0] mem_q [`TWS_DEPTH];
	logic want_q;
	logic rw_q;
	logic pend_q;
	logic on_q;
	logic busy;
	logic prog_go;

	logic bit_ev, start_ev, stop_ev, ev_data, ev7, ev8;
	logic [7:0] byte_in;
	logic match, prot, mem_we, rd_next;

	// strap and device-type compare, used for ack and state decisions
	function automatic logic dev_match(input logic [7:0] b,
		input logic [2:0] s);
		dev_match = (b[7:4] == `TWS_DEV_TYPE) && (b[3:1] == s);
	endfunction : dev_match

	// page-local increment: only the low five bits move
	function automatic logic [`TWS_AW-1:0] page_inc(
		input logic [`TWS_AW-1:0] a);
		page_inc = {a[`TWS_AW-1:5], a[4:0] + 5'h01};
	endfunction : page_inc

	// capture each bit on the rising scl edge, flag it by toggle
	always_ff @(posedge scl or negedge resetn)
	begin
		if (!resetn)
		begin
			bit_q <= 1'b0;
			tog_q <= 1'b0;
		end
		else
		begin
			bit_q <= sda_i;
			tog_q <= ~tog_q;
		end
	end

	// drive level changes only after scl falls; want_q is settled
	// a few clk cycles after the rising edge and held until the fall
	always_ff @(negedge scl or negedge resetn)
	begin
		if (!resetn)
			drv_q <= 1'b0;
		else
			drv_q <= want_q;
	end

	// release at once when a frame ends, even if scl stays high
	assign sda_oe = drv_q & on_q;
	assign sda_o = 1'b0;

	// two-flop synchronisers for pins and the bit toggle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_p <= 1'b1;
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_p <= 1'b0;
			strap_s1 <= 3'h0;
			strap_s2 <= 3'h0;
			wp_s1 <= 1'b0;
			wp_s2 <= 1'b0;
		end
		else
		begin
			scl_s1 <= scl;
			scl_s2 <= scl_s1;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_p <= sda_s2;
			tog_s1 <= tog_q;
			tog_s2 <= tog_s1;
			tog_p <= tog_s2;
			strap_s1 <= {chip_select_strap_2, chip_select_strap_1,
				chip_select_strap_0};
			strap_s2 <= strap_s1;
			wp_s1 <= write_protect;
			wp_s2 <= wp_s1;
		end
	end

	// conditions: sda moving while scl is high
	assign start_ev = scl_s2 && sda_p && !sda_s2;
	assign stop_ev = scl_s2 && !sda_p && sda_s2;
	assign bit_ev = (tog_s2 ^ tog_p) && !start_ev && !stop_ev;

	// bit events that matter: the eighth bit and the ack bit
	assign ev_data = bit_ev && (state_q != tws_pkg::ST_IDLE);
	assign ev7 = ev_data && (cnt_q == `TWS_LAST_BIT);
	assign ev8 = ev_data && (cnt_q == `TWS_ACK_BIT);
	assign byte_in = {shift_q[6:0], bit_q};
	assign match = dev_match(byte_in, strap_s2) && !busy;
	assign prot = wp_s2 &&
		(addr_q[`TWS_AW-1:`TWS_AW-2] == `TWS_PROT_TOP);
	assign mem_we = ev7 && (state_q == tws_pkg::ST_WR) && !prot;
	assign rd_next = ev8 && (((state_q == tws_pkg::ST_DEV) && rw_q)
		|| ((state_q == tws_pkg::ST_RD) && !bit_q));

	// protocol phase and bit count
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= tws_pkg::ST_IDLE;
			cnt_q <= 4'h0;
		end
		else if (start_ev)
		begin
			state_q <= tws_pkg::ST_DEV;
			cnt_q <= 4'h0;
		end
		else if (stop_ev)
			state_q <= tws_pkg::ST_IDLE;
		else if (ev7)
		begin
			cnt_q <= `TWS_ACK_BIT;
			if ((state_q == tws_pkg::ST_DEV) && !match)
				state_q <= tws_pkg::ST_IDLE;
		end
		else if (ev8)
		begin
			cnt_q <= 4'h0;
			case (state_q)
				tws_pkg::ST_DEV:
					state_q <= rw_q ? tws_pkg::ST_RD
						: tws_pkg::ST_AHI;
				tws_pkg::ST_AHI:
					state_q <= tws_pkg::ST_ALO;
				tws_pkg::ST_ALO:
					state_q <= tws_pkg::ST_WR;
				tws_pkg::ST_RD:
					if (bit_q)
						state_q <= tws_pkg::ST_IDLE;
				default:
					state_q <= state_q;
			endcase
		end
		else if (ev_data)
			cnt_q <= cnt_q + 4'h1;
	end

	// receive shifter and read/write select
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			shift_q <= 8'h00;
			rw_q <= 1'b0;
		end
		else if (ev_data && (cnt_q != `TWS_ACK_BIT))
		begin
			shift_q <= byte_in;
			if (ev7 && (state_q == tws_pkg::ST_DEV))
				rw_q <= bit_q;
		end
	end

	// address counter survives between transfers (no reset but power)
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			addr_q <= '0;
			hi_q <= 8'h00;
		end
		else if (ev7 && (state_q == tws_pkg::ST_AHI))
			hi_q <= byte_in & `TWS_HI_MASK;
		else if (ev7 && (state_q == tws_pkg::ST_ALO))
			addr_q <= {hi_q[4:0], byte_in};
		else if (ev7 && (state_q == tws_pkg::ST_WR))
			addr_q <= page_inc(addr_q);
		else if (rd_next)
			addr_q <= addr_q + 1'b1;
	end

	// array of flip-flops, erased after reset
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < `TWS_DEPTH; i++)
				mem_q[i] <= `TWS_ERASED;
		end
		else if (mem_we)
			mem_q[addr_q] <= byte_in;
	end

	// outgoing read byte, shifted one bit per clock
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			out_q <= 8'h00;
		else if (rd_next)
			out_q <= mem_q[addr_q];
		else if (ev_data && (state_q == tws_pkg::ST_RD) &&
			(cnt_q < `TWS_LAST_BIT))
			out_q <= {out_q[6:0], 1'b0};
	end

	// what sda shows during the next low phase of scl
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			want_q <= 1'b0;
		else if (start_ev || stop_ev)
			want_q <= 1'b0;
		else if (ev7)
			want_q <= (state_q != tws_pkg::ST_RD) &&
				((state_q != tws_pkg::ST_DEV) || match);
		else if (rd_next)
			want_q <= ~mem_q[addr_q][7];
		else if (ev8)
			want_q <= 1'b0;
		else if (ev_data && (state_q == tws_pkg::ST_RD))
			want_q <= ~out_q[6];
	end

	// frame activity gates the pin driver
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			on_q <= 1'b0;
		else if (start_ev)
			on_q <= 1'b1;
		else if (stop_ev)
			on_q <= 1'b0;
	end

	// pending write: data accepted, program cycle starts at the stop;
	// a restart drops it, the bytes already landed in the array
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pend_q <= 1'b0;
		else if (start_ev || stop_ev)
			pend_q <= 1'b0;
		else if (ev7 && (state_q == tws_pkg::ST_WR))
			pend_q <= 1'b1;
	end

	assign prog_go = stop_ev && pend_q;

	tws_prog_timer #(
		.PROG_CYCLES(PROG_CYCLES)
	) u_timer (
		.clk(clk),
		.resetn(resetn),
		.start(prog_go),
		.busy(busy)
	);

	// standby once idle and no program cycle runs
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			standby <= 1'b1;
		else
			standby <= (state_q == tws_pkg::ST_IDLE) && !busy;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	a_start_to_dev: assert property (start_ev |=>
		(state_q == tws_pkg::ST_DEV) && (cnt_q == 4'h0))
		else $error("start did not open device phase");

	a_stop_to_idle: assert property (stop_ev |=>
		(state_q == tws_pkg::ST_IDLE) ##1 !sda_oe)
		else $error("stop did not end the frame");

	a_ack_on_match: assert property (ev7 &&
		(state_q == tws_pkg::ST_DEV) && match |=> want_q)
		else $error("matching device word not acknowledged");

	a_nack_busy: assert property (ev7 && busy &&
		(state_q == tws_pkg::ST_DEV) |=>
		!want_q && (state_q == tws_pkg::ST_IDLE))
		else $error("device word acknowledged while busy");

	a_ack_bytes: assert property (ev7 &&
		(state_q inside {tws_pkg::ST_AHI, tws_pkg::ST_ALO,
		tws_pkg::ST_WR}) |=> want_q && (cnt_q == `TWS_ACK_BIT))
		else $error("received byte not acknowledged");

	a_page_wrap: assert property (ev7 &&
		(state_q == tws_pkg::ST_WR) |=>
		(addr_q[12:5] == $past(addr_q[12:5])) &&
		(addr_q[4:0] == $past(addr_q[4:0]) + 5'h01))
		else $error("write address left its page");

	a_read_inc: assert property (rd_next |=>
		(addr_q == $past(addr_q) + 13'h0001) &&
		(out_q == $past(mem_q[addr_q])))
		else $error("read did not advance the counter");

	a_protect: assert property (ev7 && (state_q == tws_pkg::ST_WR)
		&& wp_s2 && (addr_q[12:11] == 2'h3) |=>
		(mem_q[$past(addr_q)] == $past(mem_q[addr_q])))
		else $error("write reached protected quarter");

	a_prog_busy: assert property (prog_go |=> busy && !standby)
		else $error("program cycle did not start at stop");

endmodule : tws_eeprom

// *** tws_ctl_model.sv ***
// bus controller model: drives scl, pulls sda low through ctl_oe
// assumes a pull-up outside resolves sda from every open-drain pull
`timescale 1ns/10ps

module tws_ctl_model #(
	parameter int HALF_NS = 1200
) (
	sda,
	scl,
	ctl_oe
);
	input wire logic sda;
	output logic scl;
	output logic ctl_oe;

	// scl rests high between frames, sda released
	initial
	begin
		scl = 1'b1;
		ctl_oe = 1'b0;
	end

	// data moves a quarter phase after the fall, never with scl high
	task automatic put_bit(input logic b);
		#(HALF_NS / 4) ctl_oe = ~b;
		#(3 * HALF_NS / 4) scl = 1'b1;
		#(HALF_NS) scl = 1'b0;
	endtask : put_bit

	// sample mid high phase, well clear of both edges
	task automatic get_bit(output logic b);
		#(HALF_NS / 4) ctl_oe = 1'b0;
		#(3 * HALF_NS / 4) scl = 1'b1;
		#(HALF_NS / 2) b = sda;
		#(HALF_NS / 2) scl = 1'b0;
	endtask : get_bit

	// also serves as repeated start
	task automatic start_c();
		#(HALF_NS / 4) ctl_oe = 1'b0;
		#(3 * HALF_NS / 4) scl = 1'b1;
		#(HALF_NS / 2) ctl_oe = 1'b1;
		#(HALF_NS / 2) scl = 1'b0;
	endtask : start_c

	task automatic stop_c();
		#(HALF_NS / 4) ctl_oe = 1'b1;
		#(3 * HALF_NS / 4) scl = 1'b1;
		#(HALF_NS / 2) ctl_oe = 1'b0;
		#(HALF_NS);
	endtask : stop_c

	// nine released clocks then a start with sda high
	task automatic recover();
		logic b;
		repeat (9) get_bit(b);
		start_c();
	endtask : recover

	// ack is 1 when the target pulled sda low in the ninth clock
	task automatic byte_w(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(b);
		ack = ~b;
	endtask : byte_w

	// more high acknowledges and asks for the next byte
	task automatic byte_r(input logic more, output logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			get_bit(d[i]);
		put_bit(~more);
	endtask : byte_r

endmodule : tws_ctl_model

// *** testbench.sv ***
// self-checking bench of the two-wire memory target
// assumes tws_eeprom and tws_ctl_model; expectations from a byte model
`timescale 1ns/10ps
`include "tws_defines.svh"

module testbench;
	localparam int PROG = 400;
	logic clk;
	logic resetn;
	logic scl;
	logic ctl_oe;
	logic sda_o;
	logic sda_oe;
	logic [2:0] strap;
	logic write_protect;
	logic standby;
	wire sda;
	int n_fail;
	int checks_done;
	int seed;
	logic [7:0] mem [0:`TWS_DEPTH-1];
	logic [12:0] cnt;
	logic [12:0] a;
	logic ack;
	logic [7:0] d;

	// open drain with pull-up; either party may pull low
	assign sda = (ctl_oe | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

	tws_eeprom #(.PROG_CYCLES(tws_pkg::tws_prog_cnt_t'(PROG))) uut (
		.clk(clk), .resetn(resetn), .scl(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe),
		.chip_select_strap_2(strap[2]), .chip_select_strap_1(strap[1]),
		.chip_select_strap_0(strap[0]), .write_protect(write_protect),
		.standby(standby)
	);

	tws_ctl_model #(.HALF_NS(1200)) ctl (
		.sda(sda), .scl(scl), .ctl_oe(ctl_oe)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : check

	task automatic results();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	function automatic logic [7:0] dev(input logic rd);
		return {`TWS_DEV_TYPE, strap, rd};
	endfunction : dev

	function automatic logic prot(input logic [12:0] x);
		return write_protect && x[12:11] == `TWS_PROT_TOP;
	endfunction : prot

	// write address steps inside its page only
	function automatic logic [12:0] page_step(input logic [12:0] x);
		return {x[12:5], x[4:0] + 5'h01};
	endfunction : page_step

	task automatic send(input logic [7:0] b, input logic exp_ack);
		ctl.byte_w(b, ack);
		check(ack, exp_ack);
	endtask : send

	// bounded wait for the end of a program cycle
	task automatic wait_idle();
		int k;
		k = 0;
		while (standby !== 1'b1 && k < 3000)
		begin
			@(posedge clk);
			#1 k++;
		end
		if (k == 3000)
		begin
			n_fail++;
			results();
		end
	endtask : wait_idle

	// top address bits sent as ones: the target must ignore them
	task automatic wr(input logic [12:0] x, input int n);
		logic [7:0] b;
		ctl.start_c();
		send(dev(1'b0), 1'b1);
		send({3'h7, x[12:8]}, 1'b1);
		send(x[7:0], 1'b1);
		repeat (n)
		begin
			b = 8'($random(seed));
			send(b, 1'b1);
			if (!prot(x))
				mem[x] = b;
			x = page_step(x);
		end
		ctl.stop_c();
		check(standby, 1'b0);
		ctl.start_c();
		send(dev(1'b0), 1'b0);
		ctl.stop_c();
		wait_idle();
	endtask : wr

	task automatic rd(input int n);
		ctl.start_c();
		send(dev(1'b1), 1'b1);
		for (int i = 0; i < n; i++)
		begin
			ctl.byte_r(i < n - 1, d);
			check(d, mem[cnt]);
			cnt = cnt + 13'h0001;
		end
		ctl.stop_c();
		repeat (10) @(posedge clk);
		#1 check(standby, 1'b1);
	endtask : rd

	// dummy write loads the address, then a repeated start
	task automatic rrd(input logic [12:0] x, input int n);
		ctl.start_c();
		send(dev(1'b0), 1'b1);
		send({3'h0, x[12:8]}, 1'b1);
		send(x[7:0], 1'b1);
		cnt = x;
		rd(n);
	endtask : rrd

	// hang guard well beyond the longest sequence
	initial
	begin
		#8000000;
		n_fail++;
		results();
	end

	initial
	begin
		seed = 95;
		n_fail = 0;
		checks_done = 0;
		resetn = 1'b0;
		write_protect = 1'b0;
		strap = 3'($random(seed));
		for (int i = 0; i < `TWS_DEPTH; i++)
			mem[i] = `TWS_ERASED;
		repeat (8) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (4) @(posedge clk);
		#1 check(standby, 1'b1);
		check({sda_oe, sda_o}, 2'h0);
		ctl.recover();
		send({4'h5, strap, 1'b0}, 1'b0);
		ctl.stop_c();
		ctl.start_c();
		send({`TWS_DEV_TYPE, ~strap, 1'b0}, 1'b0);
		ctl.stop_c();
		// over-long page write rolls back onto its first bytes
		a = 13'($random(seed));
		wr(a, 34);
		rrd({a[12:5], 5'h00}, 32);
		rd(2);
		write_protect = 1'b1;
		wr(13'h17FF, 1);
		wr(13'h1800, 2);
		rrd(13'h17FF, 3);
		write_protect = 1'b0;
		rrd(13'h1FFF, 2);
		repeat (3)
		begin
			a = 13'($random(seed));
			wr(a, 1 + ($unsigned($random(seed)) % 4));
			rrd(a, 2);
		end
		results();
	end

endmodule : testbench
